/* core/mpas_sequencer.sv */
// Purpose: 4-bit cascadable microprogram next-address slice
// Assumes: inputs synchronous to clk_in; APB port only observes and presets
// Notes: address outputs and carry out are combinational by design
`timescale 1ns/1ps
module mpas_sequencer
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic source_select_low_in,
   input wire logic source_select_high_in,
   input wire logic stack_enable_n_in,
   input wire logic push_not_pop_in,
   input wire logic hold_register_load_n_in,
   input wire mpas_pkg::mpas_addr_t hold_data_in,
   input wire mpas_pkg::mpas_addr_t direct_address_inputs_in,
   input wire mpas_pkg::mpas_addr_t force_one_in,
   input wire logic force_zero_n_in,
   input wire logic output_enable_n_in,
   input wire logic incrementer_carry_in_in,
   output logic incrementer_carry_out_out,
   output mpas_pkg::mpas_addr_t y_out,
   output logic y_oe_out,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import mpas_pkg::*;

   // ==========================================================
   // state
   mpas_addr_t counter_q;
   mpas_addr_t counter_d;
   mpas_addr_t hold_q;
   mpas_addr_t hold_d;
   mpas_idx_t index_q;
   mpas_idx_t index_d;
   mpas_addr_t stack_q [`MPAS_DEPTH];
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [31:0] preset_q;

   // ==========================================================
   // helpers
   function automatic mpas_idx_t mpas_step(input mpas_idx_t idx, input logic up);
      mpas_step = up ? mpas_idx_t'(idx + 2'h1) : mpas_idx_t'(idx - 2'h1);
   endfunction : mpas_step

   function automatic logic mpas_hit(input logic [11:0] addr, input logic [11:0] ofs);
      mpas_hit = (addr == ofs);
   endfunction : mpas_hit

   // ==========================================================
   // source and stack decode
   mpas_src_t src;
   mpas_stk_t stk_op;
   mpas_addr_t stack_top;
   mpas_addr_t src_word;
   mpas_addr_t y_word;
   mpas_addr_t inc_word;
   mpas_idx_t push_idx;

   assign src = mpas_src_t'({source_select_high_in, source_select_low_in});
   assign stk_op = stack_enable_n_in ? MPAS_STK_HOLD
                 : (push_not_pop_in ? MPAS_STK_PUSH : MPAS_STK_POP);
   assign stack_top = stack_q[index_q];
   assign push_idx = mpas_step(index_q, 1'b1);

   always_comb
   begin
      case (src)
         MPAS_SRC_COUNTER: src_word = counter_q;
         MPAS_SRC_HOLD: src_word = hold_q;
         MPAS_SRC_STACK: src_word = stack_top;
         MPAS_SRC_DIRECT: src_word = direct_address_inputs_in;
         default: src_word = counter_q;
      endcase
   end

   // force-zero beats force-one beats source
   assign y_word = force_zero_n_in ? (src_word | force_one_in) : `MPAS_RST_ADDR;
   assign y_out = y_word;
   assign y_oe_out = ~output_enable_n_in;

   mpas_incr u_incr
   (
      .word_in(y_word),
      .incrementer_carry_in_in(incrementer_carry_in_in),
      .sum_out(inc_word),
      .incrementer_carry_out_out(incrementer_carry_out_out)
   );

   // ==========================================================
   // APB decode
   logic apb_setup;
   logic apb_done;
   logic hit_state;
   logic hit_stack;
   logic hit_preset;
   logic hit_any;
   logic preset_wr;
   logic [31:0] rd_word;

   assign apb_setup = psel & ~penable & ~pready_q;
   assign apb_done = psel & penable & pready_q;
   assign hit_state = mpas_hit(paddr, `MPAS_OFS_STATE);
   assign hit_stack = mpas_hit(paddr, `MPAS_OFS_STACK);
   assign hit_preset = mpas_hit(paddr, `MPAS_OFS_PRESET);
   assign hit_any = hit_state | hit_stack | hit_preset;
   assign preset_wr = apb_done & pwrite & hit_preset & ~pslverr_q;
   assign rd_word = hit_state ? {21'h0, incrementer_carry_out_out, index_q, hold_q, counter_q}
                  : hit_stack ? {16'h0, stack_q[3], stack_q[2], stack_q[1], stack_q[0]}
                  : hit_preset ? preset_q
                  : `MPAS_RST_WORD;

   // ==========================================================
   // next state
   assign counter_d = preset_wr ? pwdata[`MPAS_F_CNT_LO +: `MPAS_ADDR_W]
                    : inc_word;
   assign hold_d = hold_register_load_n_in ? hold_q : hold_data_in;
   assign index_d = preset_wr ? pwdata[`MPAS_F_IDX_LO +: `MPAS_IDX_W]
                  : (stk_op == MPAS_STK_PUSH) ? push_idx
                  : (stk_op == MPAS_STK_POP) ? mpas_step(index_q, 1'b0)
                  : index_q;

   // ==========================================================
   // registers, edge only
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         counter_q <= `MPAS_RST_ADDR;
         hold_q <= `MPAS_RST_ADDR;
         index_q <= `MPAS_RST_IDX;
      end
      else
      begin
         counter_q <= counter_d;
         hold_q <= hold_d;
         index_q <= index_d;
      end
   end

   // push writes counter into new top
   always_ff @(posedge clk_in)
   begin
      for (int i = 0; i < `MPAS_DEPTH; i++)
      begin
         if (!nrst_in)
            stack_q[i] <= `MPAS_RST_ADDR;
         else if (stk_op == MPAS_STK_PUSH && push_idx == mpas_idx_t'(i))
            stack_q[i] <= counter_q;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= `MPAS_RST_WORD;
         preset_q <= `MPAS_RST_WORD;
      end
      else
      begin
         pready_q <= apb_setup;
         if (apb_setup)
         begin
            pslverr_q <= ~hit_any;
            prdata_q <= pwrite ? `MPAS_RST_WORD : rd_word;
         end
         if (preset_wr)
            preset_q <= pwdata;
      end
   end

   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;
endmodule : mpas_sequencer

/* include/mpas_defs.svh */
// Purpose: constants of the microprogram address sequencer slice
// Assumes: one 4-bit slice, APB observation port with 32-bit data
// Notes: none
`ifndef MPAS_DEFS_SVH
`define MPAS_DEFS_SVH

// ==========================================================
// widths
`define MPAS_ADDR_W 4
`define MPAS_DEPTH 4
`define MPAS_IDX_W 2

// ==========================================================
// register offsets
`define MPAS_OFS_STATE 12'h000
`define MPAS_OFS_STACK 12'h004
`define MPAS_OFS_PRESET 12'h008

// ==========================================================
// field positions
`define MPAS_F_CNT_LO 0
`define MPAS_F_HOLD_LO 4
`define MPAS_F_IDX_LO 8
`define MPAS_F_COUT 10

// ==========================================================
// reset values
`define MPAS_RST_ADDR 4'h0
`define MPAS_RST_IDX 2'h0
`define MPAS_RST_WORD 32'h0000_0000

`endif

/* include/mpas_pkg.sv */
// Purpose: types of the microprogram address sequencer slice
// Assumes: mpas_defs.svh holds the numbers
// Notes: none
`include "mpas_defs.svh"
package mpas_pkg;
   typedef logic [`MPAS_ADDR_W-1:0] mpas_addr_t;
   typedef logic [`MPAS_IDX_W-1:0] mpas_idx_t;
   typedef enum logic [1:0] {
      MPAS_SRC_COUNTER,
      MPAS_SRC_HOLD,
      MPAS_SRC_STACK,
      MPAS_SRC_DIRECT
   } mpas_src_t;
   typedef enum logic [1:0] {
      MPAS_STK_HOLD,
      MPAS_STK_PUSH,
      MPAS_STK_POP
   } mpas_stk_t;
endpackage : mpas_pkg

/* core/mpas_incr.sv */
// Purpose: incrementer of one slice with carry chain
// Assumes: carry-in low passes the word unchanged
// Notes: combinational
`timescale 1ns/1ps
module mpas_incr
(
   input wire mpas_pkg::mpas_addr_t word_in,
   input wire logic incrementer_carry_in_in,
   output mpas_pkg::mpas_addr_t sum_out,
   output logic incrementer_carry_out_out
);
   import mpas_pkg::*;
   logic [`MPAS_ADDR_W:0] total;
   // ==========================================================
   // sum with carry
   assign total = {1'b0, word_in} + {{`MPAS_ADDR_W{1'b0}}, incrementer_carry_in_in};
   assign sum_out = total[`MPAS_ADDR_W-1:0];
   assign incrementer_carry_out_out = total[`MPAS_ADDR_W];
endmodule : mpas_incr

/* verification/mpas_sequencer_properties.sv */
// Purpose: port relations of the sequencer slice
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every sequencer instance
`timescale 1ns/1ps
module mpas_sequencer_checker
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic source_select_low_in,
   input wire logic source_select_high_in,
   input wire logic stack_enable_n_in,
   input wire logic push_not_pop_in,
   input wire mpas_pkg::mpas_addr_t direct_address_inputs_in,
   input wire mpas_pkg::mpas_addr_t force_one_in,
   input wire logic force_zero_n_in,
   input wire logic output_enable_n_in,
   input wire logic incrementer_carry_in_in,
   input wire logic incrementer_carry_out_out,
   input wire mpas_pkg::mpas_addr_t y_out,
   input wire logic y_oe_out,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready
);
   import mpas_pkg::*;
   wire [1:0] sel = {source_select_high_in, source_select_low_in};
   wire clean = force_zero_n_in && force_one_in == 4'h0;
   wire stk = !stack_enable_n_in;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   // ==========
   // sequences and checks
   sequence seq_push;
      sel == 2'h0 && clean && stk && push_not_pop_in && !psel;
   endsequence
   sequence seq_pop;
      sel == 2'h2 && clean && stk && !push_not_pop_in;
   endsequence
   sequence seq_run(bit c);
      sel == 2'h0 && clean && incrementer_carry_in_in == c && !psel ##1 sel == 2'h0 && clean;
   endsequence
   a_oe_follows: assert property
      (y_oe_out == !output_enable_n_in) else $error("oe wrong");
   a_zero_forces: assert property
      (!force_zero_n_in |-> y_out == 4'h0) else $error("zero wrong");
   a_one_forces: assert property
      (force_zero_n_in |-> (y_out & force_one_in) == force_one_in) else $error("one wrong");
   a_direct_route: assert property
      (sel == 2'h3 && clean |-> y_out == direct_address_inputs_in) else $error("direct wrong");
   a_count_up: assert property
      (seq_run(1'b1) |-> y_out == $past(y_out) + 4'h1) else $error("count wrong");
   a_count_repeat: assert property
      (seq_run(1'b0) |-> $stable(y_out)) else $error("repeat wrong");
   a_call_return: assert property
      (seq_push ##1 seq_pop |-> y_out == $past(y_out)) else $error("return wrong");
   a_carry_chain: assert property
      (incrementer_carry_out_out == (incrementer_carry_in_in && y_out == 4'hF))
      else $error("carry wrong");
   a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("ready wrong");
endmodule : mpas_sequencer_checker
bind mpas_sequencer mpas_sequencer_checker u_chk (.*);

/* verification/mpas_next_logic.sv */
// Purpose: microword decode and pipeline capture
// Assumes: cmd 0 go on,1 call,2 return,3 hold jump,4 loop,5 push
// Notes: unused direct lines carry the inverted target
`timescale 1ns/1ps
module mpas_next_logic
(
   input wire logic clk_in,
   input wire logic [2:0] cmd_in,
   input wire mpas_pkg::mpas_addr_t target_in,
   input wire mpas_pkg::mpas_addr_t y_in,
   output logic [3:0] ctl_out,
   output mpas_pkg::mpas_addr_t direct_out,
   output mpas_pkg::mpas_addr_t pipe_out
);
   import mpas_pkg::*;
   // ==========
   // decode, bits are select high, low, enable, push
   always_comb
   begin
      case (cmd_in)
         3'h1: ctl_out = 4'hD;
         3'h2: ctl_out = 4'h8;
         3'h3: ctl_out = 4'h6;
         3'h4: ctl_out = 4'hA;
         3'h5: ctl_out = 4'h1;
         default: ctl_out = 4'h2;
      endcase
   end
   assign direct_out = (cmd_in == 3'h1) ? target_in : ~target_in;
   always_ff @(posedge clk_in) pipe_out <= y_in;
endmodule : mpas_next_logic

/* verification/tb_mpas_sequencer.sv */
// Purpose: self-checking bench of the sequencer slice
// Assumes: 100 MHz clock, reset low five cycles
// Notes: table word is carry, cmd, target, expected address
`timescale 1ns/1ps
module tb_mpas_sequencer;
   import mpas_pkg::*;
   logic clk_in = 1'b0, nrst_in = 1'b0, hold_register_load_n_in = 1'b1, force_zero_n_in = 1'b1;
   logic output_enable_n_in = 1'b0, incrementer_carry_in_in = 1'b0, psel = 1'b0;
   logic penable = 1'b0, pwrite = 1'b0, er, incrementer_carry_out_out, y_oe_out, pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   mpas_addr_t hold_data_in = 4'h0, force_one_in = 4'h0, tgt = 4'h0;
   mpas_addr_t y_out, direct_address_inputs_in, pipe;
   mpas_addr_t prev_y = 4'h3;
   logic [2:0] cmd = 3'h0;
   logic [3:0] ctl;
   wire source_select_high_in, source_select_low_in, stack_enable_n_in, push_not_pop_in;
   int failures = 0, tests_run = 0;
   logic [11:0] prog [15] = '{12'h803, 12'h804, 12'h999, 12'hC05, 12'hA05, 12'h806, 12'hD07,
      12'hA07, 12'h808, 12'hB0C, 12'h80D, 12'h9FF, 12'h800, 12'h001, 12'h001};
   assign {source_select_high_in, source_select_low_in, stack_enable_n_in, push_not_pop_in} = ctl;
   mpas_sequencer DUT (.*);
   mpas_next_logic u_far (.clk_in(clk_in), .cmd_in(cmd), .target_in(tgt), .y_in(y_out),
      .ctl_out(ctl), .direct_out(direct_address_inputs_in), .pipe_out(pipe));
   always #5 clk_in = ~clk_in;
   // ==========
   // tasks
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_in);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task step(input logic [11:0] p);
      @(posedge clk_in);
      incrementer_carry_in_in <= p[11];
      cmd <= p[10:8];
      tgt <= p[7:4];
      @(negedge clk_in);
      check("y", y_out, p[3:0]);
      check("carry", incrementer_carry_out_out, p[11] && p[3:0] == 4'hF);
      check("pipe", pipe, prev_y);
      prev_y = p[3:0];
   endtask : step
   task outc(input logic oe, input logic fz, input mpas_addr_t fo, input mpas_addr_t ey);
      @(posedge clk_in);
      output_enable_n_in <= oe;
      force_zero_n_in <= fz;
      force_one_in <= fo;
      @(negedge clk_in);
      check("y", y_out, ey);
      check("oe", y_oe_out, !oe);
   endtask : outc
   task finish_test;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   initial
   begin
      #200000;
      failures++;
      finish_test;
   end
   initial
   begin
      repeat (5) @(posedge clk_in);
      nrst_in <= 1'b1;
      hold_data_in <= 4'hC;
      hold_register_load_n_in <= 1'b0;
      @(negedge clk_in);
      check("y reset", y_out, 4'h0);
      apb(1'b1, 12'h008, 32'h0000_0003);
      hold_register_load_n_in <= 1'b1;
      hold_data_in <= 4'h3;
      for (int i = 0; i < 15; i++) step(prog[i]);
      apb(1'b0, 12'h000, 32'h0);
      check("state", rd, 32'h0000_01C1);
      apb(1'b0, 12'h004, 32'h0);
      check("stack", rd, 32'h0000_00E0);
      apb(1'b0, 12'h008, 32'h0);
      check("preset", rd, 32'h0000_0003);
      apb(1'b0, 12'h00C, 32'h0);
      check("err", er, 1'b1);
      outc(1'b0, 1'b1, 4'h4, 4'h5);
      outc(1'b0, 1'b0, 4'h4, 4'h0);
      outc(1'b1, 1'b1, 4'h0, 4'h0);
      finish_test;
   end
endmodule : tb_mpas_sequencer
